// *** include/ppo_cfg.svh ***
// constants for the port pin override logic
`ifndef PPO_CFG_SVH
`define PPO_CFG_SVH

// pins in one port and register data width
`define PPO_PINS          8
`define PPO_DW            8
`define PPO_AW            4

// register offsets on the plain register port
`define PPO_OFS_DIR       4'h0
`define PPO_OFS_LATCH     4'h1
`define PPO_OFS_INPUT     4'h2
`define PPO_OFS_SYSCTL    4'h3
`define PPO_OFS_DRIVE     4'h4
`define PPO_OFS_INEN      4'h5
`define PPO_OFS_PULL      4'h6

// field positions and reset values
`define PPO_PUD_BIT       6
`define PPO_SYSCTL_RST    8'h00
`define PPO_PORT_RST      8'h00
`define PPO_RD_ZERO       8'h00
// {direction, latch, kill} pattern that turns the pull-up on
`define PPO_PULL_ON_PAT   3'b010

// synchroniser depth
`define PPO_SYNC_STAGES   2

`endif

// *** include/ppo_pkg.sv ***
// types shared by the port pin override logic
package ppo_pkg;

    typedef logic [7:0] ppo_byte_t;
    typedef logic [3:0] ppo_addr_t;

    // tracks whether the input clamp sleep is in force
    typedef enum logic [0:0] {
        PPO_AWAKE,
        PPO_ASLEEP
    } ppo_sleep_e;

endpackage : ppo_pkg

// *** src/ppo_sync.sv ***
// two-stage synchroniser for the pin input samples
`include "ppo_cfg.svh"

module ppo_sync (
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    input  wire logic                 clk_en,
    input  wire logic [`PPO_PINS-1:0] async_in,
    output logic      [`PPO_PINS-1:0] sync_out
);

    logic [`PPO_PINS-1:0] meta_q;
    logic [`PPO_PINS-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            meta_q <= `PPO_PORT_RST;
            sync_q <= `PPO_PORT_RST;
        end else if (clk_en) begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : ppo_sync

// *** src/ppo_pin_slice.sv ***
// per-pin override muxing for pull-up, driver, value and input enable
`include "ppo_cfg.svh"

module ppo_pin_slice (
    input  wire logic rstn,
    input  wire logic direction_bit,
    input  wire logic output_latch_bit,
    input  wire logic global_pullup_kill,
    input  wire logic sleep,
    input  wire logic ext_int_enable,
    input  wire logic pullup_override_enable,
    input  wire logic pullup_override_value,
    input  wire logic direction_override_enable,
    input  wire logic direction_override_value,
    input  wire logic value_override_enable,
    input  wire logic value_override_value,
    input  wire logic input_enable_override_enable,
    input  wire logic input_enable_override_value,
    input  wire logic pad_in,
    output logic      pad_out,
    output logic      pad_oe,
    output logic      pad_pullup,
    output logic      input_enable,
    output logic      schmitt_output_tap
);

    logic drive_en;
    logic pull_en;
    logic clamp;

    // driver enable before the reset tri-state
    assign drive_en = direction_override_enable ? direction_override_value
                                                : direction_bit;
    // reset tri-states the pad combinationally, with or without a clock
    assign pad_oe   = drive_en & rstn;
    // driven value, held low while the driver is off
    assign pad_out  = pad_oe & (value_override_enable ? value_override_value
                                                      : output_latch_bit);

    assign pull_en  = pullup_override_enable ? pullup_override_value
                    : ({direction_bit, output_latch_bit, global_pullup_kill}
                       == `PPO_PULL_ON_PAT);
    // pull-ups stay off throughout reset
    assign pad_pullup = pull_en & rstn;

    // sleep clamp, lifted for pins with an enabled external interrupt
    assign clamp        = sleep & ~ext_int_enable & rstn;
    assign input_enable = input_enable_override_enable
                        ? input_enable_override_value
                        : ~clamp;
    // unsynchronised tap; consumers synchronise it unless used as a clock
    assign schmitt_output_tap = pad_in & input_enable;

endmodule : ppo_pin_slice

// *** src/ppo_port.sv ***
// one general-purpose port with alternate-function overrides per pin
// Function
// - deep sleep clamps pin inputs to ground
// - enabled external interrupt lifts the clamp
// - resume sets flag on high edge-configured pin with interrupt disabled
// - pull-up follows override, else pattern 010
// - driver enable follows override, else direction
// - driven value follows override, else latch
// - toggle override inverts the output latch
// - input enable follows override, else sleep state
// - peripheral tap taken before the synchroniser
// - peripherals synchronise the tap unless clocking
// - analog line goes straight to pad
// - strobes per port, overrides per pin
// - pull-up kill bit disables pull-ups not under override
// - pull-ups disabled during reset
// - inputs unclamped in reset, active, idle
// - direction one drives latch, zero inputs
// - writing input register toggles output latch
// - reset tri-states all pins without clock
`include "ppo_cfg.svh"

module ppo_port (
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic                  clk_en,
    // register port
    input  wire logic [`PPO_AW-1:0]    reg_addr,
    input  wire logic [`PPO_DW-1:0]    reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output logic      [`PPO_DW-1:0]    reg_rdata,
    // common controls
    input  wire logic                  sleep,
    // interrupt controller view of each pin
    input  wire logic [`PPO_PINS-1:0]  ext_int_enable,
    input  wire logic [`PPO_PINS-1:0]  ext_int_edge_mode,
    output logic      [`PPO_PINS-1:0]  ext_int_flag_set,
    // alternate-function overrides, one bit per pin
    input  wire logic [`PPO_PINS-1:0]  pullup_override_enable,
    input  wire logic [`PPO_PINS-1:0]  pullup_override_value,
    input  wire logic [`PPO_PINS-1:0]  direction_override_enable,
    input  wire logic [`PPO_PINS-1:0]  direction_override_value,
    input  wire logic [`PPO_PINS-1:0]  value_override_enable,
    input  wire logic [`PPO_PINS-1:0]  value_override_value,
    input  wire logic [`PPO_PINS-1:0]  toggle_override_enable,
    input  wire logic [`PPO_PINS-1:0]  input_enable_override_enable,
    input  wire logic [`PPO_PINS-1:0]  input_enable_override_value,
    output logic      [`PPO_PINS-1:0]  schmitt_output_tap,
    // pad side
    input  wire logic [`PPO_PINS-1:0]  pad_in,
    output logic      [`PPO_PINS-1:0]  pad_out,
    output logic      [`PPO_PINS-1:0]  pad_oe,
    output logic      [`PPO_PINS-1:0]  pad_pullup,
    // common pull-up kill, for the other ports of the chip
    output logic                       global_pullup_kill
);

    // address match, shared by the write and read decoders
    function automatic logic reg_hit(input ppo_pkg::ppo_addr_t addr,
                                     input ppo_pkg::ppo_addr_t ofs);
        reg_hit = (addr == ofs);
    endfunction : reg_hit

    ppo_pkg::ppo_byte_t     direction_q;
    ppo_pkg::ppo_byte_t     latch_q;
    ppo_pkg::ppo_byte_t     latch_d;
    ppo_pkg::ppo_byte_t     sysctl_q;
    ppo_pkg::ppo_byte_t     rdata_q;
    ppo_pkg::ppo_byte_t     rdata_d;
    ppo_pkg::ppo_byte_t     toggle_mask;
    ppo_pkg::ppo_sleep_e    sleep_state_q;
    logic [`PPO_PINS-1:0]   flag_set_q;
    logic [`PPO_PINS-1:0]   flag_set_d;
    logic [`PPO_PINS-1:0]   input_sample_bit;
    logic [`PPO_PINS-1:0]   input_enable;
    logic                   resume;
    logic                   wr_dir;
    logic                   wr_latch;
    logic                   wr_input;
    logic                   wr_sysctl;

    // ------------------------------------------------------------------
    // write decode; strobes are common to every pin of the port
    // ------------------------------------------------------------------
    assign wr_dir    = reg_write & reg_hit(reg_addr, `PPO_OFS_DIR);
    assign wr_latch  = reg_write & reg_hit(reg_addr, `PPO_OFS_LATCH);
    assign wr_input  = reg_write & reg_hit(reg_addr, `PPO_OFS_INPUT);
    assign wr_sysctl = reg_write & reg_hit(reg_addr, `PPO_OFS_SYSCTL);

    // ------------------------------------------------------------------
    // system control register, all bits read/write
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sysctl_q <= `PPO_SYSCTL_RST;
        end else if (clk_en && wr_sysctl) begin
            sysctl_q <= reg_wdata;
        end
    end

    assign global_pullup_kill = sysctl_q[`PPO_PUD_BIT];

    // ------------------------------------------------------------------
    // direction register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            direction_q <= `PPO_PORT_RST;
        end else if (clk_en && wr_dir) begin
            direction_q <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // output latch: plain writes, then toggles from software and from
    // alternate functions; a toggle in the same cycle as a write acts
    // on the freshly written value
    // ------------------------------------------------------------------
    always_comb begin
        toggle_mask = toggle_override_enable;
        if (wr_input) begin
            toggle_mask = toggle_mask | reg_wdata;
        end
        latch_d = wr_latch ? reg_wdata : latch_q;
        latch_d = latch_d ^ toggle_mask;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            latch_q <= `PPO_PORT_RST;
        end else if (clk_en) begin
            latch_q <= latch_d;
        end
    end

    // ------------------------------------------------------------------
    // per-pin override slices
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `PPO_PINS; gi = gi + 1) begin : g_pin
            ppo_pin_slice u_slice (
                .rstn                         (rstn),
                .direction_bit                (direction_q[gi]),
                .output_latch_bit             (latch_q[gi]),
                .global_pullup_kill           (global_pullup_kill),
                .sleep                        (sleep),
                .ext_int_enable               (ext_int_enable[gi]),
                .pullup_override_enable       (pullup_override_enable[gi]),
                .pullup_override_value        (pullup_override_value[gi]),
                .direction_override_enable    (direction_override_enable[gi]),
                .direction_override_value     (direction_override_value[gi]),
                .value_override_enable        (value_override_enable[gi]),
                .value_override_value         (value_override_value[gi]),
                .input_enable_override_enable (input_enable_override_enable[gi]),
                .input_enable_override_value  (input_enable_override_value[gi]),
                .pad_in                       (pad_in[gi]),
                .pad_out                      (pad_out[gi]),
                .pad_oe                       (pad_oe[gi]),
                .pad_pullup                   (pad_pullup[gi]),
                .input_enable                 (input_enable[gi]),
                .schmitt_output_tap           (schmitt_output_tap[gi])
            );
        end
    endgenerate

    // the analog side of each pad bypasses this block entirely and is
    // wired pad to peripheral outside it
    // unused pins rely on the board for a defined level

    // ------------------------------------------------------------------
    // input sample register behind the synchroniser; the clamped or
    // disabled input reaches it as zero
    // ------------------------------------------------------------------
    ppo_sync u_sync (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .clk_en   (clk_en),
        .async_in (schmitt_output_tap),
        .sync_out (input_sample_bit)
    );

    // ------------------------------------------------------------------
    // sleep tracking for the wake-up flag
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sleep_state_q <= ppo_pkg::PPO_AWAKE;
        end else if (clk_en) begin
            unique case (sleep_state_q)
                ppo_pkg::PPO_AWAKE: begin
                    if (sleep) begin
                        sleep_state_q <= ppo_pkg::PPO_ASLEEP;
                    end
                end
                ppo_pkg::PPO_ASLEEP: begin
                    if (!sleep) begin
                        sleep_state_q <= ppo_pkg::PPO_AWAKE;
                    end
                end
            endcase
        end
    end

    assign resume = (sleep_state_q == ppo_pkg::PPO_ASLEEP) & ~sleep;

    // the clamp released under a high pin is a change the edge detector
    // would see, so the flag is raised on resume for disabled pins
    assign flag_set_d = {`PPO_PINS{resume}} & pad_in & ext_int_edge_mode
                      & ~ext_int_enable;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            flag_set_q <= `PPO_PORT_RST;
        end else if (clk_en) begin
            flag_set_q <= flag_set_d;
        end
    end

    assign ext_int_flag_set = flag_set_q;

    // ------------------------------------------------------------------
    // read path; data stand in the cycle after the strobe only
    // ------------------------------------------------------------------
    always_comb begin
        rdata_d = `PPO_RD_ZERO;
        if (reg_read) begin
            if (reg_hit(reg_addr, `PPO_OFS_DIR)) begin
                rdata_d = direction_q;
            end else if (reg_hit(reg_addr, `PPO_OFS_LATCH)) begin
                rdata_d = latch_q;
            end else if (reg_hit(reg_addr, `PPO_OFS_INPUT)) begin
                rdata_d = input_sample_bit;
            end else if (reg_hit(reg_addr, `PPO_OFS_SYSCTL)) begin
                rdata_d = sysctl_q;
            end else if (reg_hit(reg_addr, `PPO_OFS_DRIVE)) begin
                rdata_d = pad_oe;
            end else if (reg_hit(reg_addr, `PPO_OFS_INEN)) begin
                rdata_d = input_enable;
            end else if (reg_hit(reg_addr, `PPO_OFS_PULL)) begin
                rdata_d = pad_pullup;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rdata_q <= `PPO_RD_ZERO;
        end else if (clk_en) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

endmodule : ppo_port

// *** testbench/ppo_port_monitor.sv ***
// concurrent checks on the port pin override block
`include "ppo_cfg.svh"

module ppo_port_monitor (
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic       clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       sleep,
    input wire logic [7:0] ext_int_enable,
    input wire logic [7:0] ext_int_edge_mode,
    input wire logic [7:0] ext_int_flag_set,
    input wire logic [7:0] pullup_override_enable,
    input wire logic [7:0] pullup_override_value,
    input wire logic [7:0] direction_override_enable,
    input wire logic [7:0] direction_override_value,
    input wire logic [7:0] value_override_enable,
    input wire logic [7:0] value_override_value,
    input wire logic [7:0] input_enable_override_enable,
    input wire logic [7:0] input_enable_override_value,
    input wire logic [7:0] schmitt_output_tap,
    input wire logic [7:0] pad_in,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pullup,
    input wire logic       global_pullup_kill
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] wake_q;
    logic       kill_wr_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // pins that should flag on resume, as seen in the resume cycle
    always_ff @(posedge sys_clk) begin
        wake_q    <= pad_in & ext_int_edge_mode & ~ext_int_enable;
        kill_wr_q <= reg_wdata[`PPO_PUD_BIT];
    end

    sequence asleep_s;
        sleep && clk_en;
    endsequence
    sequence resume_s;
        asleep_s ##1 (!sleep && clk_en);
    endsequence

    oe_override_a: assert property (
        ((pad_oe ^ direction_override_value) & direction_override_enable) == 8'h00)
        else $error("driver enable ignores its override");
    value_override_a: assert property (
        ((pad_out ^ value_override_value) & value_override_enable & pad_oe) == 8'h00)
        else $error("driven value ignores its override");
    out_idle_a: assert property ((pad_out & ~pad_oe) == 8'h00)
        else $error("value on an undriven pin");
    pull_override_a: assert property (
        ((pad_pullup ^ pullup_override_value) & pullup_override_enable) == 8'h00)
        else $error("pull-up ignores its override");
    pull_kill_a: assert property (
        global_pullup_kill |-> (pad_pullup & ~pullup_override_enable) == 8'h00)
        else $error("pull-up on while killed");
    reset_quiet_a: assert property (disable iff (1'b0)
        !rstn |-> (pad_oe | pad_out | pad_pullup) == 8'h00)
        else $error("pin active during reset");
    tap_override_a: assert property (((schmitt_output_tap
        ^ (pad_in & input_enable_override_value)) & input_enable_override_enable) == 8'h00)
        else $error("input enable ignores its override");
    sleep_clamp_a: assert property (sleep |-> ((schmitt_output_tap
        ^ (pad_in & ext_int_enable)) & ~input_enable_override_enable) == 8'h00)
        else $error("sleep clamp wrong");
    awake_open_a: assert property (disable iff (1'b0) (!sleep || !rstn) |->
        ((schmitt_output_tap ^ pad_in) & ~input_enable_override_enable) == 8'h00)
        else $error("input clamped while awake");
    wake_flag_a: assert property (resume_s |=> ext_int_flag_set == wake_q)
        else $error("wrong flags on resume");
    kill_reg_a: assert property (
        (reg_write && clk_en && reg_addr == `PPO_OFS_SYSCTL) |=> global_pullup_kill == kill_wr_q)
        else $error("pull-up kill bit not written");
endmodule : ppo_port_monitor

bind ppo_port ppo_port_monitor u_mon (.*);

// *** testbench/ppo_pad_model.sv ***
// outside circuitry on the port pins
module ppo_pad_model (
    input  wire logic               sys_clk,
    input  wire ppo_pkg::ppo_byte_t pad_oe,
    input  wire ppo_pkg::ppo_byte_t pad_out,
    input  wire ppo_pkg::ppo_byte_t pad_pullup,
    input  wire ppo_pkg::ppo_byte_t ext_en,
    input  wire ppo_pkg::ppo_byte_t ext_val,
    output ppo_pkg::ppo_byte_t      pad_level
);
    timeunit 1ns;
    timeprecision 100ps;
    ppo_pkg::ppo_byte_t float_q = 8'h55;

    // an unheld, unpulled pin wanders every cycle
    always_ff @(posedge sys_clk) float_q <= ~float_q;
    // port driver wins, then an outside resistor, then the internal pull-up
    assign pad_level = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                     | (~pad_oe & ~ext_en & (pad_pullup | float_q));
endmodule : ppo_pad_model

// *** testbench/tb.sv ***
// self-checking bench for the port pin override block
`include "ppo_cfg.svh"

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic               sys_clk, rstn, clk_en, reg_write, reg_read, sleep, kill;
    ppo_pkg::ppo_addr_t reg_addr;
    ppo_pkg::ppo_byte_t reg_wdata, reg_rdata, ie_en, edge_m, flag, tap, pad_in, pad_out;
    ppo_pkg::ppo_byte_t poe, pov, doe, dov, voe, vov, toe, ieoe, ieov, pad_oe, pad_pull;
    ppo_pkg::ppo_byte_t ext_en, ext_val, dir_m, lat_m, sc_m, v;
    int                 failures, tests_run, seed;

    ppo_port DUT (
        .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .sleep(sleep), .ext_int_enable(ie_en),
        .ext_int_edge_mode(edge_m), .ext_int_flag_set(flag),
        .pullup_override_enable(poe), .pullup_override_value(pov),
        .direction_override_enable(doe), .direction_override_value(dov),
        .value_override_enable(voe), .value_override_value(vov),
        .toggle_override_enable(toe), .input_enable_override_enable(ieoe),
        .input_enable_override_value(ieov), .schmitt_output_tap(tap), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pull), .global_pullup_kill(kill)
    );
    ppo_pad_model pads (.sys_clk(sys_clk), .pad_oe(pad_oe),
        .pad_out(pad_out), .pad_pullup(pad_pull), .ext_en(ext_en), .ext_val(ext_val),
        .pad_level(pad_in));

    function automatic ppo_pkg::ppo_byte_t exp_oe();
        return (doe & dov) | (~doe & dir_m);
    endfunction : exp_oe
    function automatic ppo_pkg::ppo_byte_t exp_pull();
        return (poe & pov) | (~poe & ~dir_m & lat_m & {8{~sc_m[`PPO_PUD_BIT]}});
    endfunction : exp_pull

    task automatic chk(input ppo_pkg::ppo_byte_t seen, input ppo_pkg::ppo_byte_t exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input ppo_pkg::ppo_addr_t a, input ppo_pkg::ppo_byte_t d);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rc(input ppo_pkg::ppo_addr_t a, input ppo_pkg::ppo_byte_t exp);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rc
    task automatic summarize();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        failures++;
        summarize();
    end

    initial begin
        seed = 57312;
        {rstn, reg_write, reg_read, sleep, reg_addr, reg_wdata} = '0;
        {ie_en, edge_m, toe, voe, vov, ieoe, ieov, ext_val} = '0;
        ext_en = 8'hff;
        {poe, pov, doe, dov} = '1;
        clk_en = 1'b1;
        failures = 0;
        tests_run = 0;
        repeat (7) @(posedge sys_clk);
        #1;
        chk(pad_oe | pad_out, 8'h00);
        chk(pad_pull, 8'h00);
        @(posedge sys_clk);
        rstn <= 1'b1;
        {poe, pov, doe, dov} <= '0;
        for (int a = 0; a < 4; a++) rc(4'(a), 8'h00);
        wr(4'h9, 8'hff);
        rc(4'h9, 8'h00);
        // undriven pins now float or sit on their pull-up
        ext_en <= 8'h00;
        for (int i = 0; i < 24; i++) begin
            dir_m = 8'($random(seed));
            lat_m = 8'($random(seed));
            sc_m = 8'($random(seed));
            if (i % 4 == 0) begin
                dir_m = 8'h00;
                lat_m = 8'hff;
                sc_m[`PPO_PUD_BIT] = i[3];
            end
            wr(`PPO_OFS_DIR, dir_m);
            wr(`PPO_OFS_LATCH, lat_m);
            wr(`PPO_OFS_SYSCTL, sc_m);
            @(posedge sys_clk);
            {poe, pov, doe, dov, voe, vov} <= (i % 4 == 0) ? 48'h0
                                            : {16'($random(seed)), $random(seed)};
            @(negedge sys_clk);
            chk(pad_oe, exp_oe());
            chk(pad_out, exp_oe() & ((voe & vov) | (~voe & lat_m)));
            chk(pad_pull, exp_pull());
            chk({7'h0, kill}, {7'h0, sc_m[`PPO_PUD_BIT]});
            chk(pad_in & ~exp_oe() & exp_pull(), ~exp_oe() & exp_pull());
            rc(`PPO_OFS_SYSCTL, sc_m);
            rc(`PPO_OFS_DRIVE, exp_oe());
            rc(`PPO_OFS_PULL, exp_pull());
            rc(`PPO_OFS_INEN, 8'hff);
        end
        @(posedge sys_clk);
        {poe, pov, doe, dov, voe, vov} <= 48'h0;
        wr(`PPO_OFS_DIR, 8'h00);
        wr(`PPO_OFS_LATCH, 8'h5a);
        wr(`PPO_OFS_INPUT, 8'h0f);
        rc(`PPO_OFS_LATCH, 8'h55);
        // a write while the clock enable is low must not land
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(`PPO_OFS_LATCH, 8'hff);
        clk_en <= 1'b1;
        rc(`PPO_OFS_LATCH, 8'h55);
        wr(`PPO_OFS_DIR, 8'hff);
        @(posedge sys_clk);
        toe <= 8'h81;
        @(posedge sys_clk);
        toe <= 8'h00;
        @(negedge sys_clk);
        chk(pad_out, 8'hd4);
        wr(`PPO_OFS_DIR, 8'h00);
        v = 8'($random(seed));
        ext_en <= 8'hff;
        ext_val <= v;
        @(negedge sys_clk);
        chk(tap, v);
        repeat (2) @(posedge sys_clk);
        rc(`PPO_OFS_INPUT, v);
        @(posedge sys_clk);
        ieoe <= 8'hff;
        ieov <= 8'h00;
        @(negedge sys_clk);
        chk(tap, 8'h00);
        repeat (3) @(posedge sys_clk);
        rc(`PPO_OFS_INPUT, 8'h00);
        @(posedge sys_clk);
        {ieoe, ieov, ext_val} <= {16'h0, 8'hff};
        {ie_en, edge_m} <= 16'h0c0f;
        sleep <= 1'b1;
        @(negedge sys_clk);
        chk(tap, 8'h0c);
        @(posedge sys_clk);
        {ieoe, ieov} <= 16'h3010;
        @(negedge sys_clk);
        chk(tap, 8'h1c);
        rc(`PPO_OFS_INEN, 8'h1c);
        @(posedge sys_clk);
        sleep <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(flag, 8'h03);
        @(posedge sys_clk);
        #1;
        chk(flag, 8'h00);
        chk(tap, 8'hdf);
        summarize();
    end
endmodule : tb
